// File: rtl/sar_adc_sequencer.sv
// Acquisition, trigger, channel and result-buffer sequencing for the 12-bit converter.
module sar_adc_sequencer #(
    parameter int HALF_TCY_CLKS = 1,
    parameter int FIFO_DEPTH    = sas_pkg::FIFO_WORDS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        converter_on,
    input  wire logic        sample_request,
    input  wire logic        auto_sample,
    input  wire logic [2:0]  trigger_source,
    input  wire logic [4:0]  auto_sample_time,
    input  wire logic [3:0]  samples_per_irq,
    input  wire logic        split_buffer,
    input  wire logic        alternate_inputs,
    input  wire logic        scan_enable,
    input  wire logic [1:0]  output_format,
    input  wire logic [5:0]  clock_select,
    input  wire logic        rc_clock_select,
    input  wire logic        rc_clk_pin,
    input  wire logic [15:0] input_select_reg,
    input  wire logic [15:0] port_config_reg,
    input  wire logic [15:0] scan_select_reg,
    input  wire logic        timer_a_trig,
    input  wire logic        timer_b_trig,
    input  wire logic        ext_trig_pin,
    input  wire logic [11:0] conv_result,
    input  wire logic        irq_clear,
    input  wire logic        rd_en,
    input  wire logic [3:0]  rd_addr,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic      [3:0]  mux_channel,
    output logic      [15:0] analog_enable,
    output logic             sample_hold,
    output logic             converting,
    output logic             conv_tad_tick,
    output logic             done,
    output logic             conversion_irq_flag,
    output logic             active_half
);
    localparam int RW = sas_pkg::RES_W;
    localparam int CW = sas_pkg::CH_W;

    function automatic logic [15:0] sas_format(input logic [11:0] d, input logic [1:0] f);
        case (f)
            sas_pkg::FMT_INT:  return {{sas_pkg::PAD_W{1'b0}}, d};
            sas_pkg::FMT_SINT: return {{sas_pkg::PAD_W{d[RW-1]}}, d};
            default:           return {d, {sas_pkg::PAD_W{1'b0}}};
        endcase
    endfunction

    // Lowest selected channel at or above 'from'; wraps to the lowest one if none is left.
    function automatic logic [3:0] sas_next_set(input logic [15:0] mask, input logic [4:0] from);
        logic [3:0] hit;
        logic       found;
        hit   = 4'h0;
        found = 1'b0;
        for (int i = sas_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (mask[i] && (5'(i) >= from)) begin
                hit   = 4'(i);
                found = 1'b1;
            end
        end
        if (!found) begin
            for (int i = sas_pkg::NUM_CH - 1; i >= 0; i--) begin
                if (mask[i]) begin
                    hit = 4'(i);
                end
            end
        end
        return hit;
    endfunction

    // Pin synchronisers; only the second stage and its delayed copy feed logic.
    logic rc_meta_ff;
    logic rc_sync_ff;
    logic rc_prev_ff;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_prev_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            rc_meta_ff  <= 1'b0;
            rc_sync_ff  <= 1'b0;
            rc_prev_ff  <= 1'b0;
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            rc_meta_ff  <= rc_clk_pin;
            rc_sync_ff  <= rc_meta_ff;
            rc_prev_ff  <= rc_sync_ff;
            ext_meta_ff <= ext_trig_pin;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
        end
    end

    // Converter clock: (clock_select + 1) half instruction cycles, or the RC oscillator.
    logic [sas_pkg::DIV_W-1:0] div_ff;
    logic [sas_pkg::DIV_W-1:0] nxt_div;
    logic [sas_pkg::DIV_W-1:0] tad_period;
    logic                      div_tick;
    logic                      tad_tick;

    assign tad_period = ({10'h000, clock_select} + 16'h0001) * 16'(HALF_TCY_CLKS);
    assign div_tick   = (div_ff == tad_period - 16'h0001);
    assign tad_tick   = rc_clock_select ? (rc_sync_ff && !rc_prev_ff) : div_tick;

    always_comb begin
        nxt_div = div_ff + 16'h0001;
        if (!converter_on || div_tick || rc_clock_select) begin
            nxt_div = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // Result path: the FIFO decouples conversion from buffer writes that bus reads can stall.
    sas_stream_if #(.W(RW)) res_in ();
    sas_stream_if #(.W(RW)) res_out ();

    sas_fifo #(
        .WIDTH (RW),
        .DEPTH (FIFO_DEPTH)
    ) u_sas_fifo (
        .clk   (clk),
        .rst   (rst),
        .in_s  (res_in.snk),
        .out_s (res_out.src)
    );

    // Sequencer.
    sas_pkg::sas_state_type state_ff;
    sas_pkg::sas_state_type nxt_state;
    logic [4:0]             cnt_ff;
    logic [4:0]             nxt_cnt;
    logic [3:0]             seq_ff;
    logic [3:0]             nxt_seq;
    logic                   alt_b_ff;
    logic                   nxt_alt_b;
    logic [4:0]             scan_pos_ff;
    logic [4:0]             nxt_scan_pos;
    logic [CW-1:0]          chan_ff;
    logic [CW-1:0]          nxt_chan;
    logic                   chan_b_ff;
    logic                   nxt_chan_b;
    logic                   sample_request_prev_ff;
    logic                   trig_hit;
    logic                   seq_start;

    always_comb begin
        case (trigger_source)
            sas_pkg::TRIG_SW:    trig_hit = sample_request_prev_ff && !sample_request;
            sas_pkg::TRIG_EXT:   trig_hit = ext_sync_ff && !ext_prev_ff;
            sas_pkg::TRIG_TMR_A: trig_hit = timer_a_trig;
            sas_pkg::TRIG_TMR_B: trig_hit = timer_b_trig;
            sas_pkg::TRIG_AUTO:  trig_hit = (cnt_ff == auto_sample_time);
            default:             trig_hit = 1'b0;
        endcase
    end

    assign res_in.valid = (state_ff == sas_pkg::SAS_CONVERT) && converter_on && tad_tick
                          && (cnt_ff == sas_pkg::CONV_LAST);
    assign res_in.data  = conv_result;

    always_comb begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_seq      = seq_ff;
        nxt_alt_b    = alt_b_ff;
        nxt_scan_pos = scan_pos_ff;
        nxt_chan     = chan_ff;
        nxt_chan_b   = chan_b_ff;
        seq_start    = 1'b0;
        if (!converter_on) begin
            // Disable outranks any trigger or auto-start arriving in the same cycle.
            nxt_state    = sas_pkg::SAS_IDLE;
            nxt_cnt      = 5'h00;
            nxt_seq      = 4'h0;
            nxt_alt_b    = 1'b0;
            nxt_scan_pos = 5'h00;
        end else begin
            case (state_ff)
                sas_pkg::SAS_IDLE: begin
                    if (sample_request && !sample_request_prev_ff) begin
                        seq_start = 1'b1;
                    end
                end
                sas_pkg::SAS_SAMPLE: begin
                    if (tad_tick && cnt_ff != 5'h1F) begin
                        nxt_cnt = cnt_ff + 5'h01;
                    end
                    // A conversion only starts while the FIFO can take its result.
                    if (trig_hit && res_in.ready) begin
                        nxt_state = sas_pkg::SAS_CONVERT;
                        nxt_cnt   = 5'h00;
                    end
                end
                sas_pkg::SAS_CONVERT: begin
                    if (tad_tick) begin
                        nxt_cnt = cnt_ff + 5'h01;
                    end
                    if (res_in.valid) begin
                        nxt_state = sas_pkg::SAS_IDLE;
                        if (seq_ff == samples_per_irq) begin
                            nxt_seq      = 4'h0;
                            nxt_alt_b    = 1'b0;
                            nxt_scan_pos = 5'h00;
                        end else begin
                            nxt_seq   = seq_ff + 4'h1;
                            nxt_alt_b = alternate_inputs && !alt_b_ff;
                            if (!chan_b_ff) begin
                                nxt_scan_pos = {1'b0, chan_ff} + 5'h01;
                            end
                        end
                        seq_start = auto_sample;
                    end
                end
                default: nxt_state = sas_pkg::SAS_IDLE;
            endcase
            if (seq_start) begin
                nxt_state  = sas_pkg::SAS_SAMPLE;
                nxt_cnt    = 5'h00;
                // Choose from the next group and scan position, because an auto restart
                // must not reuse the channel of the sequence that has just finished.
                nxt_chan_b = alternate_inputs && nxt_alt_b;
                if (nxt_chan_b) begin
                    nxt_chan = input_select_reg[sas_pkg::SEL_B_LSB +: CW];
                end else if (scan_enable) begin
                    nxt_chan = sas_next_set(scan_select_reg, nxt_scan_pos);
                end else begin
                    nxt_chan = input_select_reg[sas_pkg::SEL_A_LSB +: CW];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff     <= sas_pkg::SAS_IDLE;
            cnt_ff       <= 5'h00;
            seq_ff       <= 4'h0;
            alt_b_ff     <= 1'b0;
            scan_pos_ff  <= 5'h00;
            chan_ff      <= 4'h0;
            chan_b_ff    <= 1'b0;
            sample_request_prev_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            seq_ff       <= nxt_seq;
            alt_b_ff     <= nxt_alt_b;
            scan_pos_ff  <= nxt_scan_pos;
            chan_ff      <= nxt_chan;
            chan_b_ff    <= nxt_chan_b;
            sample_request_prev_ff <= sample_request;
        end
    end

    // Buffer writer. It yields to bus reads so the array never sees both in one cycle.
    logic [RW-1:0] result_buffer [sas_pkg::BUF_WORDS];
    logic [3:0]    off_ff;
    logic [3:0]    nxt_off;
    logic          half_ff;
    logic          nxt_half;
    logic          done_ff;
    logic          nxt_done;
    logic          irq_ff;
    logic          nxt_irq;
    logic          wr_en;
    logic          irq_evt;
    logic [3:0]    wr_idx;

    assign res_out.ready = !rd_en;
    assign wr_en         = res_out.valid && res_out.ready;
    assign irq_evt       = wr_en && (off_ff == samples_per_irq);
    assign wr_idx        = split_buffer ? {half_ff, off_ff[2:0]} : off_ff;

    always_comb begin
        nxt_off  = off_ff;
        nxt_half = half_ff;
        if (wr_en) begin
            nxt_off = off_ff + 4'h1;
        end
        if (irq_evt) begin
            nxt_off  = 4'h0;
            nxt_half = split_buffer && !half_ff;
        end
        if (!converter_on) begin
            nxt_off  = 4'h0;
            nxt_half = 1'b0;
        end
        nxt_done = irq_evt || (done_ff && !seq_start);
        nxt_irq  = irq_evt || (irq_ff && !irq_clear);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            off_ff   <= 4'h0;
            half_ff  <= 1'b0;
            done_ff  <= 1'b0;
            irq_ff   <= 1'b0;
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            off_ff   <= nxt_off;
            half_ff  <= nxt_half;
            done_ff  <= nxt_done;
            irq_ff   <= nxt_irq;
            rd_data  <= sas_format(result_buffer[rd_addr], output_format);
            rd_valid <= rd_en;
        end
    end

    // No reset and no software port: contents survive reset and only results write it.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            result_buffer[wr_idx] <= res_out.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            analog_enable <= 16'h0000;
        end else begin
            analog_enable <= ~port_config_reg;
        end
    end

    assign mux_channel         = chan_ff;
    assign sample_hold         = (state_ff == sas_pkg::SAS_SAMPLE);
    assign converting          = (state_ff == sas_pkg::SAS_CONVERT);
    assign conv_tad_tick       = tad_tick;
    assign done                = done_ff;
    assign conversion_irq_flag = irq_ff;
    assign active_half         = half_ff;

    property p_sw_trigger;
        @(posedge clk) disable iff (rst)
        (state_ff == sas_pkg::SAS_SAMPLE) && converter_on && res_in.ready
        && (trigger_source == sas_pkg::TRIG_SW) && $fell(sample_request)
        |=> (state_ff == sas_pkg::SAS_CONVERT);
    endproperty
    a_sw_trigger: assert property (p_sw_trigger) else $error("Software trigger missed");

    property p_auto_trigger;
        @(posedge clk) disable iff (rst)
        (state_ff == sas_pkg::SAS_SAMPLE) && converter_on && res_in.ready
        && (trigger_source == sas_pkg::TRIG_AUTO) && (cnt_ff == auto_sample_time)
        |=> (state_ff == sas_pkg::SAS_CONVERT) && (cnt_ff == 5'h00);
    endproperty
    a_auto_trigger: assert property (p_auto_trigger) else $error("Auto-start missed");

    property p_disable_wins;
        @(posedge clk) disable iff (rst)
        !converter_on |-> !res_in.valid ##1 (state_ff == sas_pkg::SAS_IDLE);
    endproperty
    a_disable_wins: assert property (p_disable_wins) else $error("Disable did not abort");

    property p_conv_holds;
        @(posedge clk) disable iff (rst)
        (state_ff == sas_pkg::SAS_CONVERT) && converter_on && !res_in.valid
        |=> (state_ff == sas_pkg::SAS_CONVERT);
    endproperty
    a_conv_holds: assert property (p_conv_holds) else $error("Conversion ended early");

    property p_push_cause;
        @(posedge clk) disable iff (rst)
        res_in.valid |-> tad_tick && (cnt_ff == sas_pkg::CONV_LAST) && converter_on;
    endproperty
    a_push_cause: assert property (p_push_cause) else $error("Result pushed off schedule");

    property p_irq_event;
        @(posedge clk) disable iff (rst)
        wr_en && (off_ff == samples_per_irq)
        |=> conversion_irq_flag && done && (off_ff == 4'h0);
    endproperty
    a_irq_event: assert property (p_irq_event) else $error("Interrupt event not flagged");

    property p_irq_sticky;
        @(posedge clk) disable iff (rst)
        conversion_irq_flag && !irq_clear |=> conversion_irq_flag;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("Interrupt flag dropped");

    property p_half_flip;
        @(posedge clk) disable iff (rst)
        irq_evt && split_buffer && converter_on |=> (active_half != $past(active_half));
    endproperty
    a_half_flip: assert property (p_half_flip) else $error("Buffer half did not alternate");

    property p_group_a;
        @(posedge clk) disable iff (rst)
        seq_start && converter_on && !alternate_inputs && !scan_enable
        |=> (mux_channel == $past(input_select_reg[3:0]));
    endproperty
    a_group_a: assert property (p_group_a) else $error("Group A channel not selected");

    property p_tad_spacing;
        @(posedge clk) disable iff (rst)
        div_tick && !rc_clock_select && converter_on && (clock_select != 6'h00)
        |=> !div_tick;
    endproperty
    a_tad_spacing: assert property (p_tad_spacing) else $error("Converter clock too fast");
endmodule

// File: rtl/sas_fifo.sv
// Synchronous FIFO with valid/ready on both sides for conversion results.
module sas_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic   clk,
    input wire logic   rst,
    sas_stream_if.snk  in_s,
    sas_stream_if.src  out_s
);
    // DEPTH must be a power of two: the extra pointer bit tells full from empty.
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ff;
    logic [AW:0]      rd_ff;
    logic [AW:0]      nxt_wr;
    logic [AW:0]      nxt_rd;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    assign empty = (wr_ff == rd_ff);
    assign push  = in_s.valid && !full;
    assign pop   = out_s.valid && out_s.ready;

    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem[rd_ff[AW-1:0]];

    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        if (push) begin
            nxt_wr = wr_ff + {{AW{1'b0}}, 1'b1};
        end
        if (pop) begin
            nxt_rd = rd_ff + {{AW{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_s.data;
        end
    end

    property p_no_overflow;
        @(posedge clk) disable iff (rst)
        full && !pop |=> $stable(wr_ff);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("FIFO write pointer moved while full");
endmodule

// File: shared/sas_pkg.sv
// Constants, encodings and types shared by the converter sequencer files.
// Overview of operation
// - Sixteen analog inputs pass through one selector to a single sample-and-hold.
// - Results live in a sixteen-word, twelve-bit buffer that software cannot write.
// - Acquisition begins when software sets sample_request with the converter enabled.
// - Each result is stored; done and interrupt flag set once the count completes.
// - samples_per_irq gives one to sixteen sequences per interrupt; 0111 means eight.
// - split_buffer makes two eight-word halves, alternating after every interrupt event.
// - alternate_inputs clear uses group A only; set alternates group A and B.
// - scan_enable steps group A through channels marked in scan_select_reg.
// - Scanning runs low to high, restarts each interrupt; extra selections are skipped.
// - Trigger source 000 starts conversion when software clears sample_request.
// - Trigger source 111 converts after auto_sample_time converter clocks of acquisition.
// - Timer and external events also serve as triggers, three alternates in total.
// - Clearing converter_on aborts conversion, halts sequencing, writes no partial result.
// - Disable arriving together with an auto-start wins; no conversion begins.
// - Every conversion lasts fifteen converter clock periods.
// - Converter clock period is instruction cycle times half of clock_select plus one.
// - rc_clock_select picks the internal RC oscillator as converter clock.
// - port_config_reg sets analog or digital pins; input_select_reg picks channels.
// - output_format presents results as integer, signed integer or left-justified fraction.
// - Reset turns the converter off and aborts activity, leaving buffer contents intact.
package sas_pkg;
    localparam int NUM_CH     = 16;
    localparam int CH_W       = 4;
    localparam int RES_W      = 12;
    localparam int BUS_W      = 16;
    localparam int PAD_W      = BUS_W - RES_W;
    localparam int BUF_WORDS  = 16;
    localparam int FIFO_WORDS = 32;
    localparam int DIV_W      = 16;
    localparam int SEL_A_LSB  = 0;
    localparam int SEL_B_LSB  = 8;

    localparam logic [4:0] CONV_LAST = 5'h0E;

    localparam logic [2:0] TRIG_SW    = 3'h0;
    localparam logic [2:0] TRIG_EXT   = 3'h1;
    localparam logic [2:0] TRIG_TMR_A = 3'h2;
    localparam logic [2:0] TRIG_TMR_B = 3'h3;
    localparam logic [2:0] TRIG_AUTO  = 3'h7;

    localparam logic [1:0] FMT_INT   = 2'h0;
    localparam logic [1:0] FMT_SINT  = 2'h1;
    localparam logic [1:0] FMT_FRAC  = 2'h2;
    localparam logic [1:0] FMT_SFRAC = 2'h3;

    typedef enum logic [1:0] {
        SAS_IDLE,
        SAS_SAMPLE,
        SAS_CONVERT
    } sas_state_type;
endpackage

// File: shared/sas_stream_if.sv
// Valid/ready word stream between the sequencer and its result FIFO.
interface sas_stream_if #(
    parameter int W = 12
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: verification/sar_adc_sequencer_tb.sv
// Self-checking bench for the converter sequencer.
module sar_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, converter_on, sample_request, auto_sample, split_buffer;
    logic alternate_inputs, scan_enable, rc_clock_select, rc_clk_pin, timer_a_trig;
    logic timer_b_trig, ext_trig_pin, irq_clear, rd_en, rd_valid, sample_hold;
    logic converting, conv_tad_tick, done, conversion_irq_flag, active_half;
    logic [2:0]  trigger_source;
    logic [4:0]  auto_sample_time;
    logic [3:0]  samples_per_irq, rd_addr, mux_channel;
    logic [1:0]  output_format;
    logic [5:0]  clock_select;
    logic [11:0] conv_result;
    logic [15:0] input_select_reg, port_config_reg, scan_select_reg, rd_data, analog_enable;
    int          err_count = 0;
    int          num_checks = 0;

    sar_adc_sequencer #(.HALF_TCY_CLKS(1)) u_sar_adc_sequencer (.*);
    sas_core_model u_sas_core_model (.clk(clk), .converting(converting), .conv_result(conv_result));

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] fmt(logic [11:0] v, logic [1:0] f);
        if (f == 2'h0) return {4'h0, v};
        if (f == 2'h1) return {{4{v[11]}}, v};
        return {v, 4'h0};
    endfunction

    // Channel of the k-th sequence after an interrupt boundary.
    function automatic logic [3:0] exp_ch(int k);
        if (alternate_inputs && k % 2 == 1) return input_select_reg[11:8];
        if (!scan_enable) return input_select_reg[3:0];
        k = alternate_inputs ? k / 2 : k;
        for (int i = 0; i < 16; i++) begin
            if (scan_select_reg[i]) begin
                if (k == 0) return 4'(i);
                k--;
            end
        end
        return 4'h0;
    endfunction

    task automatic rd(logic [3:0] a, logic [11:0] v);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        chk("rd_valid", {15'h0, rd_valid}, 16'h0001);
        chk("rd_data", rd_data, fmt(v, output_format));
        @(negedge clk);
    endtask

    task automatic run(logic [2:0] trig, logic [3:0] n);
        int w;
        int k;
        int cc;
        trigger_source = trig;
        samples_per_irq = n;
        u_sas_core_model.q.delete();
        converter_on = 1'b1;
        @(negedge clk);
        sample_request = 1'b1;
        w = 0;
        cc = 0;
        do begin
            @(negedge clk);
            w++;
            if (w == 4) sample_request = 1'b0;
            k = u_sas_core_model.q.size();
            if (sample_hold === 1'b1 && k <= int'(n))
                chk("mux_channel", {12'h0, mux_channel}, {12'h0, exp_ch(k)});
            if (converting === 1'b1) cc++;
        end while (done !== 1'b1 && w < 200);
        chk("irq", {15'h0, conversion_irq_flag}, 16'h0001);
        chk("active_half", {15'h0, active_half}, {15'h0, split_buffer});
        if (clock_select == 6'h00)
            chk("conv_cycles", 16'(cc), 16'((int'(n) + 1) * 15));
        converter_on = 1'b0;
        repeat (3) @(negedge clk);
        chk("busy", {14'h0, sample_hold, converting}, 16'h0000);
        chk("irq_hold", {15'h0, conversion_irq_flag}, 16'h0001);
        for (int i = 0; i <= n; i++) rd(4'(i), u_sas_core_model.q[i]);
        irq_clear = 1'b1;
        @(negedge clk);
        irq_clear = 1'b0;
        @(negedge clk);
        chk("irq_clear", {15'h0, conversion_irq_flag}, 16'h0000);
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end

    initial begin
        void'($urandom(32'h3B02));
        {rst, converter_on, sample_request, auto_sample, split_buffer, alternate_inputs} = 6'h24;
        {scan_enable, rc_clock_select, rc_clk_pin, timer_a_trig, timer_b_trig, ext_trig_pin} = 6'h0;
        {irq_clear, rd_en, rd_addr, output_format, clock_select, trigger_source} = '0;
        auto_sample_time = 5'h01;
        samples_per_irq = 4'h0;
        port_config_reg = 16'($urandom);
        input_select_reg = 16'($urandom);
        scan_select_reg = 16'hFFFF;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk("analog_enable", analog_enable, ~port_config_reg);
        run(3'h7, 4'h1);
        chk("mux_channel", {12'h0, mux_channel}, {12'h0, input_select_reg[3:0]});
        output_format = 2'h1;
        run(3'h0, 4'h0);
        output_format = 2'h2;
        split_buffer = 1'b1;
        alternate_inputs = 1'b1;
        run(3'h7, 4'h2);
        {split_buffer, alternate_inputs, scan_enable, timer_a_trig} = 4'h3;
        scan_select_reg = 16'($urandom) | 16'h8421;
        clock_select = 6'h01;
        output_format = 2'h3;
        run(3'h2, 4'h3);
        close_out();
    end
endmodule

// File: verification/sas_core_model.sv
// Behavioural analog core that hands one fresh result to each conversion.
module sas_core_model (
    input  wire logic        clk,
    input  wire logic        converting,
    output logic      [11:0] conv_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] q[$];
    logic        was_conv = 1'b0;
    initial conv_result = 12'h000;
    // The value changes only as a conversion opens, because the core samples it late.
    always @(negedge clk) begin
        if (converting === 1'b1 && !was_conv) begin
            conv_result = 12'($urandom);
            q.push_back(conv_result);
        end
        was_conv = (converting === 1'b1);
    end
endmodule
